// *** rtl/pcc_regs.svh ***
/*
 * Constants of the port configuration command handler: identifiers,
 * payload byte positions, flag bit positions, reset defaults and sizes.
 * Assumes it is included by bare name from the package and the modules.
 */
`ifndef PCC_REGS_SVH
`define PCC_REGS_SVH

// Report size in bytes, and the last byte index
`define PCC_REPORT_BYTES   64
`define PCC_LAST_IDX       6'h3f

// Command identifiers
`define PCC_ID_PORT_MODE   8'h93
`define PCC_ID_FW_NAME     8'h94

// Byte positions inside a report
`define PCC_POS_ID         6'h00
`define PCC_POS_FLAGS      6'h01
`define PCC_POS_FILL       6'h02

// Flag bit positions inside the flags byte
`define PCC_FLAG_ACK_BIT   0
`define PCC_FLAG_SLEW_BIT  2

// Programmed defaults taken at every reset
`define PCC_DEF_ACK        1'b1
`define PCC_DEF_SLEW       1'b0
`define PCC_DEF_FILL       8'hff

`endif

// *** rtl/pcc_pkg.sv ***
/*
 * Types of the port configuration command handler.
 * Assumes pcc_regs.svh is on the include path.
 */
`default_nettype none
`include "pcc_regs.svh"

package pcc_pkg;

  // Port mode as handed to the slave engine
  typedef struct packed {
    logic       data_ack;   // Acknowledge data bytes
    logic       slew_en;    // Slew-rate control on
    logic [7:0] fill_byte;  // Idle fill byte for empty reads
  } pcc_mode_t;

  // Reply state machine, one-hot
  typedef enum logic [1:0] {
    PCC_ST_IDLE = 2'b01,
    PCC_ST_SEND = 2'b10
  } pcc_state_t;

endpackage

`default_nettype wire

// *** rtl/pcc_name_rom.sv ***
/*
 * Firmware name string table: one ASCII byte per index, zero past the
 * end so the terminator and the report padding come out as zeros.
 * Assumes a purely combinational caller on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module pcc_name_rom (
  input  wire logic [5:0] addr,      // String byte index
  output logic      [7:0] data_out   // ASCII byte or zero
);

  // Name text is arbitrary, not tied to any real product
  always_comb begin
    case (addr)
      6'h00:   data_out = 8'h50;  // P
      6'h01:   data_out = 8'h43;  // C
      6'h02:   data_out = 8'h43;  // C
      6'h03:   data_out = 8'h20;  // space
      6'h04:   data_out = 8'h30;  // 0
      6'h05:   data_out = 8'h31;  // 1
      6'h06:   data_out = 8'h2e;  // .
      6'h07:   data_out = 8'h30;  // 0
      6'h08:   data_out = 8'h30;  // 0
      default: data_out = 8'h00;  // Terminator and padding
    endcase
  end

endmodule

`default_nettype wire

// *** rtl/pcc_top.sv ***
/*
 * Command handler for the port mode and firmware name commands of a
 * report-based bridge. Receives 64-byte command reports as a byte stream,
 * keeps the volatile port mode, answers the name query with a 64-byte
 * report, and picks the byte for each read of the serial slave port.
 * Assumes the report stream comes from logic on the same clock and that
 * report boundaries are never lost, so byte counting stays aligned.
 */
// Operation
// - Port mode command updates slave port mode
// - Mode volatile, defaults return on reset
// - Payload: flags byte, then idle fill byte
// - Flags bit 0 enables data acknowledge
// - Flags bit 2 enables slew-rate control
// - Name query replies zero-terminated ASCII name
// - Reply byte 0 echoes command identifier
// - All reports exactly 64 bytes, padded
`timescale 1ns/100ps
`default_nettype none
`include "pcc_regs.svh"

module pcc_top
  import pcc_pkg::*;
(
  input  wire logic       clk,             // 200 MHz device clock
  input  wire logic       rst_n,           // Async reset, active low
  input  wire logic       rx_valid,        // Command report byte present
  input  wire logic [7:0] rx_data,         // Command report byte
  input  wire logic       tx_ready,        // Reply sink takes a byte
  output logic            tx_valid,        // Reply byte present
  output logic      [7:0] tx_data,         // Reply byte
  output logic            tx_last,         // Last byte of a reply report
  output pcc_mode_t       port_mode,       // Mode for the slave engine
  output logic            mode_update,     // Pulse: mode just rewritten
  input  wire logic       slave_rd,        // Master reads one byte
  input  wire logic       txbuf_empty,     // Transmit buffer has no data
  input  wire logic [7:0] txbuf_data,      // Head of transmit buffer
  output logic      [7:0] slave_rd_byte    // Byte served to the master
);

  // Receive side
  logic [5:0]  rx_idx_reg;        // Byte index within current report
  logic [5:0]  rx_idx_next;
  logic [7:0]  rx_id_reg;         // Identifier of current report
  logic [7:0]  rx_id_next;
  logic [7:0]  flags_reg;         // Flags byte held until fill arrives
  logic [7:0]  flags_next;

  // Mode state
  pcc_mode_t   mode_reg;          // Current port mode
  pcc_mode_t   mode_next;
  logic        upd_reg;           // Update pulse
  logic        upd_next;

  // Reply side
  pcc_state_t  state_reg;         // Reply state
  pcc_state_t  state_next;
  logic [5:0]  tx_idx_reg;        // Index of byte now offered
  logic [5:0]  tx_idx_next;
  logic        tx_valid_reg;
  logic        tx_valid_next;
  logic [7:0]  tx_data_reg;
  logic [7:0]  tx_data_next;
  logic        tx_last_reg;
  logic        tx_last_next;

  // Slave read byte
  logic [7:0]  rd_byte_reg;
  logic [7:0]  rd_byte_next;

  // Decode wires
  wire logic        at_id;        // Byte 0 of a report arrives
  wire logic        at_flags;     // Byte 1 arrives
  wire logic        at_fill;      // Byte 2 arrives
  wire logic        at_end;       // Byte 63 arrives
  wire logic [7:0]  cur_id;       // Identifier seen for this byte
  wire logic        is_mode_cmd;  // Report is a port mode command
  wire logic        is_name_cmd;  // Report is a name query
  wire logic        start_reply;  // Launch a name reply
  wire logic        tx_fire;      // Reply byte accepted
  wire logic        tx_at_end;    // Offered byte is the 64th
  wire logic [7:0]  rom_byte;     // Name byte for tx_idx_reg
  wire logic [5:0]  tx_idx_inc;   // Next reply index

  // Position match, reused for every byte slot
  function automatic logic pos_is(input logic [5:0] idx,
                                  input logic [5:0] pos);
    pos_is = (idx == pos);
  endfunction

  // Name table; index i of the reply carries string byte i-1
  pcc_name_rom u_rom (
    .addr     (tx_idx_reg),
    .data_out (rom_byte)
  );

  // Every report counts 64 bytes; index wraps at the end
  assign at_id       = rx_valid && pos_is(rx_idx_reg, `PCC_POS_ID);
  assign at_flags    = rx_valid && pos_is(rx_idx_reg, `PCC_POS_FLAGS);
  assign at_fill     = rx_valid && pos_is(rx_idx_reg, `PCC_POS_FILL);
  assign at_end      = rx_valid && pos_is(rx_idx_reg, `PCC_LAST_IDX);
  assign cur_id      = at_id ? rx_data : rx_id_reg;
  assign is_mode_cmd = (cur_id == `PCC_ID_PORT_MODE);
  assign is_name_cmd = (cur_id == `PCC_ID_FW_NAME);
  // A query landing during a reply is dropped, no queue is kept
  assign start_reply = at_end && is_name_cmd &&
                       (state_reg == PCC_ST_IDLE);
  assign tx_fire     = tx_valid_reg && tx_ready;
  assign tx_at_end   = pos_is(tx_idx_reg, `PCC_LAST_IDX);
  assign tx_idx_inc  = tx_idx_reg + 6'h01;

  // Report byte counter and header capture
  always_comb begin
    rx_idx_next = rx_valid ? rx_idx_reg + 6'h01 : rx_idx_reg;
    rx_id_next  = at_id ? rx_data : rx_id_reg;
    flags_next  = at_flags ? rx_data : flags_reg;
  end

  // Port mode update on the fill byte of a mode command
  always_comb begin
    mode_next = mode_reg;
    upd_next  = 1'b0;
    if (at_fill && is_mode_cmd) begin
      // Only bits 0 and 2 matter; others are ignored
      mode_next.data_ack  = flags_reg[`PCC_FLAG_ACK_BIT];
      mode_next.slew_en   = flags_reg[`PCC_FLAG_SLEW_BIT];
      mode_next.fill_byte = rx_data;
      upd_next            = 1'b1;
    end
  end

  // Reply state machine
  always_comb begin
    state_next    = state_reg;
    tx_idx_next   = tx_idx_reg;
    tx_valid_next = tx_valid_reg;
    tx_data_next  = tx_data_reg;
    tx_last_next  = tx_last_reg;
    case (state_reg)
      PCC_ST_IDLE: begin
        if (start_reply) begin
          state_next    = PCC_ST_SEND;
          tx_idx_next   = 6'h00;
          tx_valid_next = 1'b1;
          tx_data_next  = `PCC_ID_FW_NAME;
          tx_last_next  = 1'b0;
        end
      end
      PCC_ST_SEND: begin
        if (tx_fire) begin
          if (tx_at_end) begin
            // Full 64 bytes gone; reply closed
            state_next    = PCC_ST_IDLE;
            tx_valid_next = 1'b0;
            tx_data_next  = 8'h00;
            tx_last_next  = 1'b0;
          end else begin
            // Name text, terminator, then zero padding
            tx_idx_next  = tx_idx_inc;
            tx_data_next = rom_byte;
            tx_last_next = pos_is(tx_idx_inc, `PCC_LAST_IDX);
          end
        end
      end
      default: begin
        state_next    = PCC_ST_IDLE;
        tx_valid_next = 1'b0;
        tx_data_next  = 8'h00;
        tx_last_next  = 1'b0;
      end
    endcase
  end

  // Slave read byte: fill byte when nothing waits to go out
  always_comb begin
    rd_byte_next = rd_byte_reg;
    if (slave_rd) begin
      rd_byte_next = txbuf_empty ? mode_reg.fill_byte : txbuf_data;
    end
  end

  // Receive registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_idx_reg <= 6'h00;
      rx_id_reg  <= 8'h00;
      flags_reg  <= 8'h00;
    end else begin
      rx_idx_reg <= rx_idx_next;
      rx_id_reg  <= rx_id_next;
      flags_reg  <= flags_next;
    end
  end

  // Mode registers; volatile, defaults on every reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg.data_ack  <= `PCC_DEF_ACK;
      mode_reg.slew_en   <= `PCC_DEF_SLEW;
      mode_reg.fill_byte <= `PCC_DEF_FILL;
      upd_reg            <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      upd_reg  <= upd_next;
    end
  end

  // Reply registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= PCC_ST_IDLE;
      tx_idx_reg   <= 6'h00;
      tx_valid_reg <= 1'b0;
      tx_data_reg  <= 8'h00;
      tx_last_reg  <= 1'b0;
    end else begin
      state_reg    <= state_next;
      tx_idx_reg   <= tx_idx_next;
      tx_valid_reg <= tx_valid_next;
      tx_data_reg  <= tx_data_next;
      tx_last_reg  <= tx_last_next;
    end
  end

  // Slave read byte register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_byte_reg <= `PCC_DEF_FILL;
    end else begin
      rd_byte_reg <= rd_byte_next;
    end
  end

  // Outputs straight from flops
  assign tx_valid      = tx_valid_reg;
  assign tx_data       = tx_data_reg;
  assign tx_last       = tx_last_reg;
  assign port_mode     = mode_reg;
  assign mode_update   = upd_reg;
  assign slave_rd_byte = rd_byte_reg;

endmodule

`default_nettype wire

// *** dv/pcc_top_chk.sv ***
/* Port checker of pcc_top: reset mode, mode pulse, reply framing, reads.
   Assumes one clock domain and an async active-low reset. */
`timescale 1ns/100ps
`default_nettype none
module pcc_top_chk
  import pcc_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       tx_ready,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       tx_last,
  input wire pcc_mode_t  port_mode,
  input wire logic       mode_update,
  input wire logic       slave_rd,
  input wire logic       txbuf_empty,
  input wire logic [7:0] txbuf_data,
  input wire logic [7:0] slave_rd_byte
);
  logic [5:0] beat_reg;  // Reply beats accepted, wraps per report
  // Beat counter frames the reply independently of the design
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) beat_reg <= 6'h00;
    else if (tx_valid && tx_ready) beat_reg <= beat_reg + 6'h01;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  rst_mode_a: assert property ($rose(rst_n) |-> port_mode == 10'h2ff)
    else $error("mode not default after reset");
  pulse_once_a: assert property (mode_update |=> !mode_update)
    else $error("mode update pulse too long");
  mode_hold_a: assert property ($changed(port_mode) |-> mode_update)
    else $error("mode changed without update pulse");
  rd_byte_a: assert property (slave_rd |=> slave_rd_byte ==
    ($past(txbuf_empty) ? $past(port_mode.fill_byte) : $past(txbuf_data)))
    else $error("wrong byte served to master");
  rd_hold_a: assert property (!slave_rd |=> $stable(slave_rd_byte))
    else $error("read byte moved without request");
  tx_hold_a: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable({tx_data, tx_last}))
    else $error("reply byte not held while stalled");
  last_beat_a: assert property (tx_last |->
    tx_valid && beat_reg == 6'h3f)
    else $error("last flag off the 64th beat");
  reply_id_a: assert property (tx_valid && beat_reg == 6'h00
    |-> tx_data == 8'h94)
    else $error("reply byte 0 not the query identifier");
  reply_end_a: assert property (tx_valid && tx_ready && tx_last
    |=> !tx_valid)
    else $error("reply runs past 64 bytes");
endmodule
bind pcc_top pcc_top_chk u_chk (.clk(clk), .rst_n(rst_n),
  .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
  .tx_last(tx_last), .port_mode(port_mode), .mode_update(mode_update),
  .slave_rd(slave_rd), .txbuf_empty(txbuf_empty),
  .txbuf_data(txbuf_data), .slave_rd_byte(slave_rd_byte));
`default_nettype wire

// *** dv/pcc_host_model.sv ***
/* Host side reply sink: takes reply reports with random stalls.
   Assumes replies are offered as a valid/ready byte stream. */
`timescale 1ns/100ps
`default_nettype none
module pcc_host_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic tx_valid,
  output var  logic tx_ready
);
  // Stalls one beat in four so held bytes are exercised
  always @(posedge clk or negedge rst_n)
    if (!rst_n) tx_ready <= 1'b0;
    else tx_ready <= !tx_valid || ($urandom % 4 != 0);
endmodule
`default_nettype wire

// *** dv/pcc_top_tb.sv ***
/* Self-checking bench of pcc_top: mode commands, name reply, reads.
   Assumes pcc_host_model sinks replies and pcc_top_chk is bound. */
`timescale 1ns/100ps
`default_nettype none
module pcc_top_tb
  import pcc_pkg::*;
();
  logic clk = 0, rst_n = 0, rx_valid = 0, slave_rd = 0, txbuf_empty = 0;
  logic [7:0] rx_data = 0, txbuf_data = 0, tx_data, slave_rd_byte;
  logic tx_ready, tx_valid, tx_last, mode_update, rd_pend = 0;
  pcc_mode_t port_mode;
  int num_errors = 0, n_tests = 0;
  logic [9:0] mq[$];         // Expected modes
  logic [8:0] bq[$];         // Expected {last, byte} of replies
  logic [7:0] rq[$];         // Expected read bytes
  logic [7:0] cur_fill = 8'hff, fl, nb;
  string nm = "PCC 01.00";   // Name string chosen for the design
  always #2.5 clk = ~clk;
  pcc_top DUT (.clk(clk), .rst_n(rst_n), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .port_mode(port_mode),
    .mode_update(mode_update), .slave_rd(slave_rd),
    .txbuf_empty(txbuf_empty), .txbuf_data(txbuf_data),
    .slave_rd_byte(slave_rd_byte));
  pcc_host_model u_host (.clk(clk), .rst_n(rst_n), .tx_valid(tx_valid),
    .tx_ready(tx_ready));
  task report(input logic [9:0] g, e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task chk_mode(input pcc_mode_t g, e);
    report(g, e);
  endtask
  task chk_beat(input logic [8:0] g, e);
    report({1'b0, g}, {1'b0, e});
  endtask
  task chk_rd(input logic [7:0] g, e);
    report({2'b0, g}, {2'b0, e});
  endtask
  // Oldest read note, or an inverted one when none is waiting
  function automatic logic [7:0] pop_rd(input logic [7:0] seen);
    pop_rd = rq.size() ? rq.pop_front() : ~seen;
  endfunction
  task close_out;
    num_errors += mq.size() + bq.size() + rq.size();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watcher: an unexpected mode or read meets an inverted note and fails; an unexpected beat meets 1ff
  always @(posedge clk) begin
    if (rst_n && mode_update)
      chk_mode(port_mode, mq.size() ? mq.pop_front() : ~port_mode);
    if (rst_n && tx_valid && tx_ready)
      chk_beat({tx_last, tx_data}, bq.size() ? bq.pop_front() : 9'h1ff);
    if (rd_pend)
      chk_rd(slave_rd_byte, pop_rd(slave_rd_byte));
    rd_pend <= rst_n && slave_rd;
  end
  // One 64-byte report, random gaps and padding
  task send(input logic [7:0] id, f, b);
    for (int i = 0; i < 64; i++) begin
      if ($urandom % 8 == 0) begin
        rx_valid <= 0;
        @(posedge clk);
      end
      rx_valid <= 1;
      rx_data <= i == 0 ? id : i == 1 ? f : i == 2 ? b : 8'($urandom);
      @(posedge clk);
    end
    rx_valid <= 0;
    // One idle edge so a following report never re-drives in this step
    @(posedge clk);
  endtask
  task settle;
    for (int k = 0; k < 400 && mq.size() + bq.size() + rq.size(); k++)
      @(posedge clk);
    repeat (3) @(posedge clk);
  endtask
  // Back-to-back reads; the task lowers the request after the sixth
  task reads;
    logic [7:0] d;
    logic e;
    repeat (6) begin
      d = 8'($urandom);
      e = 1'($urandom % 2);
      slave_rd <= 1;
      txbuf_empty <= e;
      txbuf_data <= d;
      rq.push_back(e ? cur_fill : d);
      @(posedge clk);
    end
    slave_rd <= 0;
  endtask
  task do_reset;
    rst_n <= 0;
    repeat (8) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    #1 chk_mode(port_mode, 10'h2ff);
    cur_fill = 8'hff;
    @(posedge clk);
  endtask
  initial begin
    #100000;
    num_errors++;
    close_out();
  end
  initial begin
    void'($urandom(32'h50393daf));
    do_reset();
    reads();
    for (int f = 0; f < 4; f++) begin
      fl = 8'($urandom);
      mq.push_back({f[0], f[1], fl});
      cur_fill = fl;
      send(8'h93, {5'h00, f[1], 1'b0, f[0]}, fl);
      settle();
      reads();
      settle();
    end
    send(8'h92, 8'h05, 8'h12);
    for (int i = 0; i < 64; i++) begin
      nb = i == 0 ? 8'h94 : i < 10 ? nm[i-1] : 8'h00;
      bq.push_back({i == 63, nb});
    end
    send(8'h94, 8'h00, 8'h00);
    settle();
    do_reset();
    reads();
    settle();
    close_out();
  end
endmodule
`default_nettype wire
